// file: rtl/sensor_monitor_config.sv
// sensor monitor configuration registers and measurement sequencer
// assumes an apb master on pclk and a converter delivering one word per adc_valid
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_monitor_consts.svh"
// Functional notes
// - offset source is calibration logic when select is 0, programmed when 1
// - programmed 8-bit offset in bits 15..8 applies only while select is 1
// - history clear bit erases history, holds until software writes 0
// - discard 3 symbols after enable when bit is 0, 6 when 1; resets to 1
// - average 3 symbols when bit is 0, 5 when 1
// - converter clock 12.5, 6.25, 3.125, 3.125 MHz by code; resets to 1
// - force bit enables monitors at once
// - without force, monitors enable only after media-side link is up
// - monitor reset bit holds monitors in reset; it resets to 1
// - readback select: 0..4 supplies and temperature, 5..7 reserved
// - normal decimation factor field, reset value 4
// - gain calibration decimation factor field, reset value 4
// - offset calibration decimation factor field, reset value 4
// - with sequencer bypassed, monitor the bypass-selected sensor only
// - with sequencer bypassed, sensor held in reset unless release bit is 1
// - bypass bit 0 lets sequencer run sensors, 1 gives software control
// - read-only 16-bit readback register shows selected sensor data
module sensor_monitor_config
	import sensor_monitor_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input  wire logic              pclk,          // device clock, 25 MHz
	input  wire logic              presetn,       // async reset, active low
	input  wire logic              psel,          // apb select
	input  wire logic              penable,       // apb access phase
	input  wire logic              pwrite,        // apb write
	input  wire logic [11:0]       paddr,         // apb byte address
	input  wire logic [31:0]       pwdata,        // apb write data
	output logic      [31:0]       prdata,        // apb read data
	output logic                   pready,        // apb ready
	output logic                   pslverr,       // apb error, unmapped
	input  wire logic              link_up,       // media-side link is up
	input  wire logic              adc_valid,     // converter word strobe
	input  wire logic [DATA_W-1:0] adc_data,      // converter word
	output logic                   adc_clk,       // converter clock
	output logic      [2:0]        sensor_sel,    // sensor being measured
	output logic                   sensor_reset   // sensor held in reset
);
	logic [15:0]       ctrl_ff;
	logic [15:0]       ofs_ff;
	logic [15:0]       sel_ff;
	logic [15:0]       seq_ff;
	logic [31:0]       prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;
	mon_state_e        state_ff;
	mon_state_e        nxt_state;
	sensor_t           sensor_ff;
	logic              sensor_reset_ff;
	logic              discarding_ff;
	logic [3:0]        sym_cnt_ff;
	logic [2:0]        dec_cnt_ff;
	logic [DATA_W+2:0] acc_ff;
	logic [DATA_W-1:0] cal_offset_ff;
	logic              store_ff;
	logic [DATA_W-1:0] store_data_ff;
	sensor_t           store_addr_ff;
	logic [DATA_W-1:0] readback;
	logic              enabled;
	logic              bypass;
	logic [2:0]        dec_field;
	logic [2:0]        dec_last;
	logic              sym_tick;
	logic [3:0]        discard_n;
	logic [3:0]        average_n;
	logic [DATA_W+2:0] acc_sum;
	logic [DATA_W-1:0] avg_value;
	logic [DATA_W-1:0] offset_applied;
	logic              avg_done;
	logic              acc_write;
	logic              acc_read;
	logic [9:0]        widx;

	// which register index an address selects; any other is unmapped
	function automatic logic mapped(input logic [9:0] idx);
		mapped = idx == `IDX_CTRL || idx == `IDX_OFFSET || idx == `IDX_SELECT
			|| idx == `IDX_SEQ || idx == `IDX_READBACK;
	endfunction

	function automatic logic [DATA_W-1:0] mean(input logic [DATA_W+2:0] s,
		input logic five);
		mean = five ? DATA_W'(s / 5) : DATA_W'(s / 3);
	endfunction

	assign widx      = paddr[11:2];
	assign acc_write = psel && penable && pready_ff && pwrite;
	assign acc_read  = psel && !penable;
	assign bypass    = seq_ff[`F_BYPASS];
	assign enabled   = !ctrl_ff[`F_HOLD] && (ctrl_ff[`F_FORCE] || link_up);
	assign discard_n = ctrl_ff[`F_DISCARD] ? `DISCARD_MANY : `DISCARD_FEW;
	assign average_n = ctrl_ff[`F_AVERAGE] ? `AVERAGE_MANY : `AVERAGE_FEW;

	// bits without a function here are stored only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `RST_CTRL;
			ofs_ff  <= `RST_OFFSET;
			sel_ff  <= `RST_SELECT;
			seq_ff  <= `RST_SEQ;
		end else if (acc_write) begin
			case (widx)
				`IDX_CTRL:   ctrl_ff <= pwdata[15:0];
				`IDX_OFFSET: ofs_ff  <= pwdata[15:0];
				`IDX_SELECT: sel_ff  <= pwdata[15:0];
				`IDX_SEQ:    seq_ff  <= pwdata[15:0];
				default:     ;
			endcase
		end
	end

	// answers in the access phase after a one-cycle setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= acc_read;
			pslverr_ff <= acc_read && !mapped(widx);
			if (acc_read && !pwrite) begin
				case (widx)
					`IDX_CTRL:     prdata_ff <= {16'h0000, ctrl_ff};
					`IDX_OFFSET:   prdata_ff <= {16'h0000, ofs_ff};
					`IDX_SELECT:   prdata_ff <= {16'h0000, sel_ff};
					`IDX_SEQ:      prdata_ff <= {16'h0000, seq_ff};
					`IDX_READBACK: prdata_ff <= (sel_ff[`F_RDSEL_HI:`F_RDSEL_LO] > `SENSOR_LAST)
						? 32'h0000_0000 : 32'(readback);
					default:       prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	always_comb begin
		case (state_ff)
			ST_DC_CAL:   dec_field = sel_ff[`F_DDEC_HI:`F_DDEC_LO];
			ST_GAIN_CAL: dec_field = sel_ff[`F_GDEC_HI:`F_GDEC_LO];
			default:     dec_field = sel_ff[`F_NDEC_HI:`F_NDEC_LO];
		endcase
	end

	// a factor of zero passes every word
	assign dec_last = (dec_field == 3'h0) ? 3'h0 : dec_field - 3'h1;
	assign sym_tick = adc_valid && !sensor_reset_ff && state_ff != ST_IDLE
		&& dec_cnt_ff >= dec_last;
	assign acc_sum  = acc_ff + (DATA_W+3)'(adc_data);
	assign avg_value = mean(acc_sum, ctrl_ff[`F_AVERAGE]);
	assign avg_done = sym_tick && !discarding_ff && sym_cnt_ff + 4'h1 >= average_n;
	assign offset_applied = ctrl_ff[`F_OFS_SEL]
		? DATA_W'($signed(ofs_ff[`F_OFSV_HI:`F_OFSV_LO]))
		: cal_offset_ff;

	always_comb begin
		nxt_state = state_ff;
		if (!enabled) begin
			nxt_state = ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE:     nxt_state = bypass ? ST_RUN : ST_DC_CAL;
				ST_DC_CAL:   nxt_state = avg_done ? ST_GAIN_CAL : ST_DC_CAL;
				ST_GAIN_CAL: nxt_state = avg_done ? ST_RUN : ST_GAIN_CAL;
				ST_RUN:      nxt_state = ST_RUN;
				default:     nxt_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// raw words counted toward one decimated symbol
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_cnt_ff <= 3'h0;
		end else if (state_ff == ST_IDLE || sensor_reset_ff || sym_tick) begin
			dec_cnt_ff <= 3'h0;
		end else if (adc_valid) begin
			dec_cnt_ff <= dec_cnt_ff + 3'h1;
		end
	end

	// discard after each enable of a sensor, then average
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discarding_ff <= 1'b1;
			sym_cnt_ff    <= 4'h0;
			acc_ff        <= '0;
		end else if (state_ff == ST_IDLE || sensor_reset_ff || avg_done) begin
			discarding_ff <= 1'b1;
			sym_cnt_ff    <= 4'h0;
			acc_ff        <= '0;
		end else if (sym_tick && discarding_ff) begin
			if (sym_cnt_ff + 4'h1 >= discard_n) begin
				discarding_ff <= 1'b0;
				sym_cnt_ff    <= 4'h0;
			end else begin
				sym_cnt_ff <= sym_cnt_ff + 4'h1;
			end
		end else if (sym_tick) begin
			sym_cnt_ff <= sym_cnt_ff + 4'h1;
			acc_ff     <= acc_sum;
		end
	end

	// the offset calibration cancels the level it measures
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_offset_ff <= '0;
		end else if (avg_done && state_ff == ST_DC_CAL) begin
			cal_offset_ff <= DATA_W'(-avg_value);
		end
	end

	// history is frozen while the clear bit stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_ff      <= 1'b0;
			store_data_ff <= '0;
			store_addr_ff <= 3'h0;
		end else begin
			store_ff      <= avg_done && state_ff == ST_RUN && !ctrl_ff[`F_HIST_CLR];
			store_data_ff <= avg_value + offset_applied;
			store_addr_ff <= sensor_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sensor_ff <= 3'h0;
		end else if (bypass) begin
			sensor_ff <= sel_ff[`F_BYPSEL_HI:`F_BYPSEL_LO];
		end else if (state_ff != ST_RUN) begin
			sensor_ff <= 3'h0;
		end else if (avg_done) begin
			sensor_ff <= (sensor_ff >= `SENSOR_LAST) ? 3'h0 : sensor_ff + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sensor_reset_ff <= 1'b1;
		end else if (!enabled) begin
			sensor_reset_ff <= 1'b1;
		end else if (bypass) begin
			sensor_reset_ff <= !sel_ff[`F_BYP_REL];
		end else begin
			sensor_reset_ff <= 1'b0;
		end
	end

	assign sensor_sel   = sensor_ff;
	assign sensor_reset = sensor_reset_ff;

	result_mem #(
		.DW (DATA_W),
		.AW (3)
	) u_result_mem (
		.clk        (pclk),
		.rstn       (presetn),
		.wr_en      (store_ff),
		.wr_addr    (store_addr_ff),
		.wr_data    (store_data_ff),
		.clr        (ctrl_ff[`F_HIST_CLR]),
		.rd_addr    (sel_ff[`F_RDSEL_HI:`F_RDSEL_LO]),
		.rd_data_ff (readback)
	);

	adc_clock_divider u_adc_clock_divider (
		.clk        (pclk),
		.rstn       (presetn),
		.rate_code  (ctrl_ff[`F_CLKD_HI:`F_CLKD_LO]),
		.adc_clk_ff (adc_clk)
	);

	AST_HOLD_RESET: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[`F_HOLD] |=> sensor_reset && state_ff == ST_IDLE)
		else $error("monitors not held in reset");
	AST_NO_LINK: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_ff[`F_FORCE] && !link_up |=> state_ff == ST_IDLE && sensor_reset)
		else $error("monitors ran without link or force");
	AST_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[`F_FORCE] && !ctrl_ff[`F_HOLD] && state_ff == ST_IDLE |=> state_ff != ST_IDLE)
		else $error("force did not start monitors");
	AST_BYPASS_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		bypass |=> sensor_sel == $past(sel_ff[`F_BYPSEL_HI:`F_BYPSEL_LO]))
		else $error("bypass sensor not selected");
	AST_BYPASS_REL: assert property (@(posedge pclk) disable iff (!presetn)
		bypass && enabled |=> sensor_reset == !$past(sel_ff[`F_BYP_REL]))
		else $error("bypass release not followed");
	AST_HIST: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[`F_HIST_CLR] [*3] |=> readback == '0)
		else $error("history not erased");
	AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
		avg_done && state_ff == ST_RUN && ctrl_ff[`F_OFS_SEL] && !ctrl_ff[`F_HIST_CLR]
		|=> store_ff && store_data_ff ==
		$past(avg_value) + DATA_W'($signed($past(ofs_ff[`F_OFSV_HI:`F_OFSV_LO]))))
		else $error("programmed offset not applied");
	AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped(widx) |=> pready && pslverr)
		else $error("unmapped access not refused");
	// calibration, counts, history and bus order
	AST_CAL_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
		avg_done && !ctrl_ff[`F_OFS_SEL]
		|=> store_data_ff == $past(avg_value) + $past(cal_offset_ff))
		else $error("calibration offset not applied");
	AST_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
		sym_tick && discarding_ff && sym_cnt_ff >= (ctrl_ff[`F_DISCARD] ? 4'h5 : 4'h2)
		|=> !discarding_ff)
		else $error("discard count not kept");
	AST_AVERAGE: assert property (@(posedge pclk) disable iff (!presetn)
		sym_tick && !discarding_ff && sym_cnt_ff == (ctrl_ff[`F_AVERAGE] ? 4'h4 : 4'h2) |-> avg_done)
		else $error("average count not kept");
	AST_RESERVED_RB: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && widx == `IDX_READBACK
		&& sel_ff[`F_RDSEL_HI:`F_RDSEL_LO] > `SENSOR_LAST |=> prdata == 32'h0000_0000)
		else $error("reserved readback code not zero");
	AST_HIST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[`F_HIST_CLR] && !(acc_write && widx == `IDX_CTRL) |=> ctrl_ff[`F_HIST_CLR])
		else $error("history clear bit changed by itself");
	AST_HIST_NO_STORE: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_ff[`F_HIST_CLR] |=> !store_ff)
		else $error("result stored while history clear stands");
	AST_SEQ_CAL: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_RUN && $past(state_ff) == ST_IDLE |-> $past(bypass))
		else $error("sequencer skipped calibration");
	AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(psel && !penable))
		else $error("ready without setup");
endmodule
`default_nettype wire

// file: rtl/sensor_monitor_consts.svh
// offsets, field positions, reset values and timing counts of the sensor monitor
// assumes inclusion by bare name from the configuration module, the clock divider and the bench
`ifndef SENSOR_MONITOR_CONSTS_SVH
`define SENSOR_MONITOR_CONSTS_SVH
// register indices and reset values; byte address is four times the index
`define IDX_CTRL      10'h1E2
`define IDX_OFFSET    10'h1E7
`define IDX_SELECT    10'h1E8
`define IDX_SEQ       10'h1E9
`define IDX_READBACK  10'h1EA
`define RST_CTRL      16'h0025
`define RST_OFFSET    16'h0012
`define RST_SELECT    16'h0920
`define RST_SEQ       16'h036D
// control register fields
`define F_OFS_SEL     15
`define F_HIST_CLR    6
`define F_DISCARD     5
`define F_AVERAGE     4
`define F_CLKD_HI     3
`define F_CLKD_LO     2
`define F_FORCE       1
`define F_HOLD        0
// offset register fields
`define F_OFSV_HI     15
`define F_OFSV_LO     8
// select register fields
`define F_BYP_REL     15
`define F_RDSEL_HI    14
`define F_RDSEL_LO    12
`define F_NDEC_HI     11
`define F_NDEC_LO     9
`define F_GDEC_HI     8
`define F_GDEC_LO     6
`define F_DDEC_HI     5
`define F_DDEC_LO     3
`define F_BYPSEL_HI   2
`define F_BYPSEL_LO   0
// sequencer register field
`define F_BYPASS      14
// symbol counts and last sensor code
`define DISCARD_FEW   4'h3
`define DISCARD_MANY  4'h6
`define AVERAGE_FEW   4'h3
`define AVERAGE_MANY  4'h5
`define SENSOR_LAST   3'h4
// device and converter clock rates in kHz and half periods in clock cycles
`define PCLK_KHZ      25000
`define ADC_KHZ_FAST  12500
`define ADC_KHZ_MID   6250
`define ADC_KHZ_SLOW  3125
`define ADC_HALF_FAST (`PCLK_KHZ / (2 * `ADC_KHZ_FAST))
`define ADC_HALF_MID  (`PCLK_KHZ / (2 * `ADC_KHZ_MID))
`define ADC_HALF_SLOW (`PCLK_KHZ / (2 * `ADC_KHZ_SLOW))
`endif

// file: rtl/sensor_monitor_pkg.sv
// types shared by the sensor monitor modules
// assumes the constants header sits beside it
package sensor_monitor_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DC_CAL,
		ST_GAIN_CAL,
		ST_RUN
	} mon_state_e;
	typedef logic [2:0] sensor_t;
endpackage

// file: rtl/adc_clock_divider.sv
// divides pclk down to the sensor converter clock
// assumes pclk at 25 MHz and a two-bit rate code
`timescale 1ns/1ps
`default_nettype none
`include "sensor_monitor_consts.svh"
module adc_clock_divider (
	input  wire logic       clk,        // device clock
	input  wire logic       rstn,       // async reset, active low
	input  wire logic [1:0] rate_code,  // converter clock code
	output logic            adc_clk_ff  // converter clock
);
	logic [2:0] cnt_ff;
	logic [2:0] half;

	always_comb begin
		case (rate_code)
			2'h0:    half = 3'(`ADC_HALF_FAST);
			2'h1:    half = 3'(`ADC_HALF_MID);
			default: half = 3'(`ADC_HALF_SLOW);
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff     <= 3'h0;
			adc_clk_ff <= 1'b0;
		end else if (cnt_ff + 3'h1 >= half) begin
			cnt_ff     <= 3'h0;
			adc_clk_ff <= ~adc_clk_ff;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end

	AST_CLK_FAST: assert property (@(posedge clk) disable iff (!rstn)
		(rate_code == 2'h0) [*2] |-> adc_clk_ff != $past(adc_clk_ff))
		else $error("converter clock not at half pclk for code 0");
	AST_CLK_SLOW: assert property (@(posedge clk) disable iff (!rstn)
		(rate_code == 2'h3) [*8] |-> adc_clk_ff != $past(adc_clk_ff, 4))
		else $error("converter clock stalled for code 3");
endmodule
`default_nettype wire

// file: rtl/result_mem.sv
// per-sensor history of logged results with a registered read port
// assumes one write and one read a cycle; clear empties every entry not written in the same cycle
`timescale 1ns/1ps
`default_nettype none
module result_mem #(
	parameter int DW = 16,
	parameter int AW = 3
) (
	input  wire logic          clk,        // device clock
	input  wire logic          rstn,       // async reset, active low
	input  wire logic          wr_en,      // store a result
	input  wire logic [AW-1:0] wr_addr,    // sensor written
	input  wire logic [DW-1:0] wr_data,    // result value
	input  wire logic          clr,        // erase all history
	input  wire logic [AW-1:0] rd_addr,    // sensor read
	output logic      [DW-1:0] rd_data_ff  // read value, zero if empty
);
	logic [DW-1:0]    mem_ff [2**AW];
	logic [2**AW-1:0] valid_ff;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	// a store in the clearing cycle survives
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid_ff <= '0;
		end else begin
			for (int i = 0; i < 2**AW; i++) begin
				if (wr_en && wr_addr == AW'(i)) begin
					valid_ff[i] <= 1'b1;
				end else if (clr) begin
					valid_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= valid_ff[rd_addr] ? mem_ff[rd_addr] : '0;
		end
	end
endmodule
`default_nettype wire

// file: tb/sensor_adc_model.sv
// converter stand-in: one word strobe every gap+1 cycles while the sensor is out of reset
// assumes gap and level are held steady by the bench during a measurement
`timescale 1ns/1ps
`default_nettype none
module sensor_adc_model (
	input  wire logic        clk,          // device clock
	input  wire logic        rstn,         // async reset, active low
	input  wire logic        sensor_reset, // sensor held in reset
	input  wire logic [3:0]  gap,          // idle cycles between words
	input  wire logic [15:0] level,        // word value
	output logic             adc_valid,    // word strobe
	output logic      [15:0] adc_data      // word, scrambled between strobes
);
	logic [3:0]  cnt_ff;
	logic        valid_ff;
	logic [15:0] data_ff;
	// between strobes the data bus flips every cycle so stale words never look valid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 4'h0;
			valid_ff <= 1'b0;
			data_ff <= 16'h0000;
		end else if (sensor_reset || cnt_ff < gap) begin
			cnt_ff <= sensor_reset ? 4'h0 : cnt_ff + 4'h1;
			valid_ff <= 1'b0;
			data_ff <= ~data_ff;
		end else begin
			cnt_ff <= 4'h0;
			valid_ff <= 1'b1;
			data_ff <= level;
		end
	end
	assign adc_valid = valid_ff;
	assign adc_data = data_ff;
endmodule
`default_nettype wire

// file: tb/sensor_monitor_config_tb_top.sv
// register-level bench of the sensor monitor configuration block
// assumes the converter model is compiled first and the constants header is on the path
`timescale 1ns/1ps
`default_nettype none
`include "sensor_monitor_consts.svh"
module sensor_monitor_config_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        link_up, adc_valid, adc_clk, sensor_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] adc_data, level;
	logic [2:0]  sensor_sel;
	logic [3:0]  gap;
	int          mismatches, cmp_count;
	always #20 pclk = ~pclk;
	sensor_monitor_config u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_up(link_up), .adc_valid(adc_valid), .adc_data(adc_data), .adc_clk(adc_clk),
		.sensor_sel(sensor_sel), .sensor_reset(sensor_reset)
	);
	sensor_adc_model u_adc (
		.clk(pclk), .rstn(presetn), .sensor_reset(sensor_reset), .gap(gap),
		.level(level), .adc_valid(adc_valid), .adc_data(adc_data)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 20) begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, idx, wd, rd, err);
		check("write error", {31'h0, err}, 32'h0);
	endtask
	task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp,
			input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, idx, 32'h0, rd, err);
		check(what, rd, exp);
		check("pslverr", {31'h0, err}, {31'h0, exp_err});
	endtask
	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (sensor_reset !== v && n < 100) begin
			@(posedge pclk);
			n++;
		end
		check("sensor_reset", {31'h0, sensor_reset}, {31'h0, v});
		if (sensor_reset !== v) begin
			stop_test();
		end
	endtask
	// poll the readback register until the expected result appears or the bound runs out
	task automatic poll_rb(input logic [31:0] exp);
		logic [31:0] rd;
		logic        err;
		int          n;
		n = 0;
		apb(1'b0, `IDX_READBACK, 32'h0, rd, err);
		while (rd !== exp && n < 250) begin
			apb(1'b0, `IDX_READBACK, 32'h0, rd, err);
			n++;
		end
		check("readback", rd, exp);
		if (rd !== exp) begin
			stop_test();
		end
	endtask
	task automatic clk_half(input int exp);
		int   n;
		logic last;
		n = 0;
		last = adc_clk;
		while (adc_clk === last && n < 20) begin
			@(posedge pclk);
			n++;
		end
		last = adc_clk;
		n = 0;
		while (adc_clk === last && n < 20) begin
			@(posedge pclk);
			n++;
		end
		check("adc_clk half period", n, exp);
		if (n >= 20) begin
			stop_test();
		end
	endtask
	int          half[4] = '{1, 2, 4, 4};
	logic [2:0]  sens[2] = '{3'h2, 3'h4};
	logic [15:0] lvl[2] = '{16'h0064, 16'h0005};
	logic [7:0]  ofs[2] = '{8'hFE, 8'h10};
	logic [3:0]  gp[2] = '{4'h3, 4'h0};
	logic [31:0] res[2] = '{32'h0062, 32'hFFA1};
	logic [31:0] ctl[2] = '{32'h8006, 32'h0036};
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		link_up = 1'b0;
		level = 16'h0000;
		gap = 4'h0;
		mismatches = 0;
		cmp_count = 0;
		repeat (6) @(posedge pclk);
		check("sensor_reset in reset", {31'h0, sensor_reset}, 32'h1);
		presetn <= 1'b1;
		rd_chk("ctrl", `IDX_CTRL, 32'h0025, 1'b0);
		rd_chk("offset", `IDX_OFFSET, 32'h0012, 1'b0);
		rd_chk("select", `IDX_SELECT, 32'h0920, 1'b0);
		rd_chk("seq", `IDX_SEQ, 32'h036D, 1'b0);
		rd_chk("readback", `IDX_READBACK, 32'h0, 1'b0);
		wr(`IDX_CTRL, 32'h7F85);
		rd_chk("ctrl reserved", `IDX_CTRL, 32'h7F85, 1'b0);
		wr(`IDX_OFFSET, 32'hABCD);
		rd_chk("offset rw", `IDX_OFFSET, 32'hABCD, 1'b0);
		wr(`IDX_READBACK, 32'h1234);
		rd_chk("readback ro", `IDX_READBACK, 32'h0, 1'b0);
		rd_chk("unmapped", 10'h1E3, 32'h0, 1'b1);
		for (int c = 0; c < 4; c++) begin
			wr(`IDX_CTRL, 32'h21 | (c << 2));
			repeat (10) @(posedge pclk);
			clk_half(half[c]);
		end
		wr(`IDX_CTRL, 32'h0024);
		repeat (20) @(posedge pclk);
		check("no start without link", {31'h0, sensor_reset}, 32'h1);
		link_up <= 1'b1;
		wait_rst(1'b0);
		wr(`IDX_CTRL, 32'h0025);
		wait_rst(1'b1);
		link_up <= 1'b0;
		wr(`IDX_CTRL, 32'h0026);
		wait_rst(1'b0);
		wr(`IDX_SEQ, 32'h4000);
		wr(`IDX_SELECT, 32'h0923);
		repeat (10) @(posedge pclk);
		check("bypass held", {31'h0, sensor_reset}, 32'h1);
		wr(`IDX_SELECT, 32'h8923);
		wait_rst(1'b0);
		check("bypass sensor", {29'h0, sensor_sel}, 32'h3);
		for (int i = 0; i < 2; i++) begin
			gap <= gp[i];
			level <= lvl[i];
			wr(`IDX_OFFSET, {16'h0, ofs[i], 8'h12});
			wr(`IDX_CTRL, ctl[i]);
			wr(`IDX_SELECT, 32'h8320 | (sens[i] << 12) | sens[i]);
			poll_rb(res[i]);
			check("measured sensor", {29'h0, sensor_sel}, {29'h0, sens[i]});
		end
		wr(`IDX_SELECT, 32'hD324);
		rd_chk("reserved readback code", `IDX_READBACK, 32'h0, 1'b0);
		wr(`IDX_SELECT, 32'hC324);
		wr(`IDX_CTRL, 32'h8066);
		repeat (5) @(posedge pclk);
		rd_chk("cleared history", `IDX_READBACK, 32'h0, 1'b0);
		rd_chk("clear bit held", `IDX_CTRL, 32'h8066, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
